// File: core/srx_top.sv
// serial receiver control: enable, error interrupts, clock-source select
//
// Added by the designer: the placing of the registers and the APB slave port.
`include "srx_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module srx_top #(
  parameter int DIV_W = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`SRX_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial pins
  input wire logic rxd_pin,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_n,
  // interrupt
  output logic irq
);
  import srx_pkg::*;
  if (DIV_W < 2 || DIV_W > 16) begin : g_chk
    $error("DIV_W must be 2 to 16");
  end
  srx_rx_if rxif();
  srx_rx_core u_core (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .rx(rxif.eng)
  );
  // control registers
  logic rx_irq_on;
  logic rx_on;
  logic rx_fault_irq_on;
  logic clk_src_sel_hi;
  logic clk_src_sel_lo;
  logic sync_mode;
  logic par_on;
  logic clk_pin_dir_bit;
  logic clk_pin_level_bit;
  logic [DIV_W-1:0] div_val;
  logic [2:0] irq_mask;
  // status
  logic [`SRX_NFLAGS-1:0] flags;
  logic [`SRX_NFLAGS-1:0] armed;
  logic [`SRX_NFLAGS-1:0] flag_set;
  logic [3:0] framing_fault_count;
  logic [3:0] parity_fault_count;
  srx_byte_t rx_data;
  // apb decode
  logic apb_done;
  logic wr_en;
  logic rd_en;
  logic mapped;
  assign apb_done = psel && penable && pready;
  assign wr_en = apb_done && pwrite && mapped;
  assign rd_en = apb_done && !pwrite && mapped;
  function automatic logic hit(input logic [`SRX_ADDR_W-1:0] a,
                               input logic [`SRX_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction
  // decides whether the clock pin carries the internal clock
  function automatic logic drives_clk(input logic sync, input logic hi,
                                      input logic lo);
    drives_clk = !hi && (sync || lo);
  endfunction
  always_comb begin
    mapped = hit(paddr, `SRX_CTRL_OFS) || hit(paddr, `SRX_MODE_OFS) ||
             hit(paddr, `SRX_PIN_OFS) || hit(paddr, `SRX_DIV_OFS) ||
             hit(paddr, `SRX_STAT_OFS) || hit(paddr, `SRX_DATA_OFS) ||
             hit(paddr, `SRX_MASK_OFS);
  end
  // one wait state, then ready for a single cycle
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
    end
  end
  logic [31:0] next_prdata;
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (hit(paddr, `SRX_CTRL_OFS)) begin
      next_prdata[`SRX_CTRL_RXIRQ] = rx_irq_on;
      next_prdata[`SRX_CTRL_RXON] = rx_on;
      next_prdata[`SRX_CTRL_FLTIRQ] = rx_fault_irq_on;
      next_prdata[`SRX_CTRL_SELHI] = clk_src_sel_hi;
      next_prdata[`SRX_CTRL_SELLO] = clk_src_sel_lo;
    end else if (hit(paddr, `SRX_MODE_OFS)) begin
      next_prdata[`SRX_MODE_SYNC] = sync_mode;
      next_prdata[`SRX_MODE_PAR] = par_on;
    end else if (hit(paddr, `SRX_PIN_OFS)) begin
      next_prdata[`SRX_PIN_DIR] = clk_pin_dir_bit;
      next_prdata[`SRX_PIN_LVL] = clk_pin_level_bit;
    end else if (hit(paddr, `SRX_DIV_OFS)) begin
      next_prdata[DIV_W-1:0] = div_val;
    end else if (hit(paddr, `SRX_STAT_OFS)) begin
      next_prdata[`SRX_NFLAGS-1:0] = flags;
      next_prdata[11:8] = framing_fault_count;
      next_prdata[15:12] = parity_fault_count;
    end else if (hit(paddr, `SRX_DATA_OFS)) begin
      next_prdata[7:0] = rx_data;
    end else if (hit(paddr, `SRX_MASK_OFS)) begin
      next_prdata[2:0] = irq_mask;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      prdata <= (psel && penable && !pready && !pwrite) ? next_prdata : 32'h0000_0000;
      pslverr <= psel && penable && !pready && !mapped;
    end
  end
  // control register writes
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rx_irq_on <= 1'b0;
      rx_on <= 1'b0;
      rx_fault_irq_on <= 1'b0;
      clk_src_sel_hi <= 1'b0;
      clk_src_sel_lo <= 1'b0;
    end else if (wr_en && hit(paddr, `SRX_CTRL_OFS)) begin
      rx_irq_on <= pwdata[`SRX_CTRL_RXIRQ];
      rx_on <= pwdata[`SRX_CTRL_RXON];
      rx_fault_irq_on <= pwdata[`SRX_CTRL_FLTIRQ];
      clk_src_sel_hi <= pwdata[`SRX_CTRL_SELHI];
      clk_src_sel_lo <= pwdata[`SRX_CTRL_SELLO];
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      sync_mode <= 1'b0;
      par_on <= 1'b0;
      clk_pin_dir_bit <= 1'b0;
      clk_pin_level_bit <= 1'b0;
      div_val <= DIV_W'(`SRX_DIV_RST);
      irq_mask <= `SRX_MASK_RST;
    end else if (wr_en) begin
      if (hit(paddr, `SRX_MODE_OFS)) begin
        sync_mode <= pwdata[`SRX_MODE_SYNC];
        par_on <= pwdata[`SRX_MODE_PAR];
      end
      if (hit(paddr, `SRX_PIN_OFS)) begin
        clk_pin_dir_bit <= pwdata[`SRX_PIN_DIR];
        clk_pin_level_bit <= pwdata[`SRX_PIN_LVL];
      end
      if (hit(paddr, `SRX_DIV_OFS)) begin
        div_val <= pwdata[DIV_W-1:0];
      end
      if (hit(paddr, `SRX_MASK_OFS)) begin
        irq_mask <= pwdata[2:0];
      end
    end
  end
  // pin synchronisers; first stages feed only the second stages
  logic rxd_s1, rxd_s2;
  logic sck_s1, sck_s2, sck_s3;
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rxd_s1 <= 1'b1;
      rxd_s2 <= 1'b1;
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_s3 <= 1'b0;
    end else begin
      rxd_s1 <= rxd_pin;
      rxd_s2 <= rxd_s1;
      sck_s1 <= sck_i;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
    end
  end
  // internal clock: toggles each divider wrap
  logic [DIV_W-1:0] div_cnt;
  logic sck_int;
  logic div_wrap;
  assign div_wrap = (div_cnt >= div_val);
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      div_cnt <= '0;
      sck_int <= 1'b0;
    end else if (div_wrap) begin
      div_cnt <= '0;
      sck_int <= !sck_int;
    end else begin
      div_cnt <= div_cnt + DIV_W'(1);
    end
  end
  logic int_tick;
  logic ext_tick;
  assign int_tick = div_wrap && !sck_int;
  assign ext_tick = sck_s2 && !sck_s3;
  assign rxif.en = rx_on;
  assign rxif.sync_mode = sync_mode;
  assign rxif.par_on = par_on;
  assign rxif.tick = clk_src_sel_hi ? ext_tick : int_tick;
  assign rxif.rxd = rxd_s2;
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      sck_o <= 1'b0;
      sck_oe_n <= 1'b1;
    end else if (clk_src_sel_hi) begin
      sck_o <= 1'b0;
      sck_oe_n <= 1'b1;
    end else if (drives_clk(sync_mode, clk_src_sel_hi, clk_src_sel_lo)) begin
      sck_o <= sck_int;
      sck_oe_n <= 1'b0;
    end else begin
      sck_o <= clk_pin_level_bit;
      sck_oe_n <= !clk_pin_dir_bit;
    end
  end
  // flag events
  logic wr_stat;
  logic rd_stat;
  logic rd_data;
  logic byte_ok;
  assign wr_stat = wr_en && hit(paddr, `SRX_STAT_OFS);
  assign rd_stat = rd_en && hit(paddr, `SRX_STAT_OFS);
  assign rd_data = rd_en && hit(paddr, `SRX_DATA_OFS);
  assign byte_ok = rxif.done && !flags[`SRX_ST_READY];
  always_comb begin
    flag_set = '0;
    flag_set[`SRX_ST_READY] = byte_ok;
    flag_set[`SRX_ST_FULL] = byte_ok;
    flag_set[`SRX_ST_FAULT] = byte_ok && (rxif.frame_err || rxif.par_err);
    flag_set[`SRX_ST_LOW] = rxif.done && rxif.line_low;
    flag_set[`SRX_ST_OVR] = rxif.done && flags[`SRX_ST_READY];
  end

  for (genvar i = 0; i < `SRX_NFLAGS; i++) begin : g_flag
    always_ff @(posedge clk_sys) begin
      if (!nrst) begin
        flags[i] <= 1'b0;
        armed[i] <= 1'b0;
      end else begin
        if (rd_stat && flags[i]) begin
          armed[i] <= 1'b1;
        end else if (wr_stat) begin
          armed[i] <= 1'b0;
        end
        if (flag_set[i]) begin
          flags[i] <= 1'b1;
        end else if (wr_stat && !pwdata[i] && armed[i]) begin
          flags[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rx_data <= 8'h00;
    end else if (byte_ok) begin
      rx_data <= rxif.data;
    end
  end
  // counts of faulty bytes, cleared when data is read
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      framing_fault_count <= 4'h0;
      parity_fault_count <= 4'h0;
    end else begin
      framing_fault_count <= (rd_data ? 4'h0 : framing_fault_count) +
                             {3'h0, byte_ok && rxif.frame_err};
      parity_fault_count <= (rd_data ? 4'h0 : parity_fault_count) +
                            {3'h0, byte_ok && rxif.par_err};
    end
  end

  logic fault_en;
  logic [2:0] irq_req;
  assign fault_en = rx_irq_on || rx_fault_irq_on;
  assign irq_req[0] = rx_irq_on && flags[`SRX_ST_READY];
  assign irq_req[1] = fault_en && flags[`SRX_ST_FAULT];
  assign irq_req[2] = fault_en && (flags[`SRX_ST_LOW] || flags[`SRX_ST_OVR]);
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_req & irq_mask);
    end
  end

  a_rx_off_quiet: assert property (@(posedge clk_sys) disable iff (!nrst)
    !rx_on |=> !rxif.done)
    else $error("receiver active while off");
  a_flags_kept: assert property (@(posedge clk_sys) disable iff (!nrst)
    !rx_on && !rxif.done && !wr_stat |=> $stable(flags))
    else $error("flags changed when receiver switched off");
  a_rsvd_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
    pready && !pwrite && hit(paddr, `SRX_CTRL_OFS) |-> !prdata[`SRX_CTRL_RSVD])
    else $error("reserved bit read as one");
  a_ext_clk_in: assert property (@(posedge clk_sys) disable iff (!nrst)
    clk_src_sel_hi |=> sck_oe_n)
    else $error("pin driven with external clock");
  a_sync_drive: assert property (@(posedge clk_sys) disable iff (!nrst)
    sync_mode && !clk_src_sel_hi |=> !sck_oe_n && sck_o == $past(sck_int))
    else $error("sync internal clock not driven");
  a_async_pin: assert property (@(posedge clk_sys) disable iff (!nrst)
    !sync_mode && !clk_src_sel_hi && !clk_src_sel_lo
    |=> sck_oe_n == !$past(clk_pin_dir_bit) && sck_o == $past(clk_pin_level_bit))
    else $error("pin not following direction and level");
  a_async_clk_out: assert property (@(posedge clk_sys) disable iff (!nrst)
    !sync_mode && !clk_src_sel_hi && clk_src_sel_lo |=> !sck_oe_n ##1 sck_oe_n == 1'b0
      || $past(clk_src_sel_hi) || $past(sync_mode) || !$past(clk_src_sel_lo))
    else $error("async clock output missing");
  a_irq_off: assert property (@(posedge clk_sys) disable iff (!nrst)
    !rx_irq_on && !rx_fault_irq_on |=> !irq)
    else $error("interrupt with both enables clear");
  a_fault_alone: assert property (@(posedge clk_sys) disable iff (!nrst)
    !rx_irq_on && rx_fault_irq_on && flags[`SRX_ST_FAULT] && irq_mask[1] |=> irq)
    else $error("fault request not raised");
  a_data_irq: assert property (@(posedge clk_sys) disable iff (!nrst)
    rx_irq_on && flags[`SRX_ST_READY] && irq_mask[0] |=> irq)
    else $error("data request not raised");
  a_one_no_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr_stat && flags[`SRX_ST_READY] && !armed[`SRX_ST_READY] |=> flags[`SRX_ST_READY])
    else $error("flag cleared without prior read");
endmodule // srx_top
`default_nettype wire

// File: core/srx_defines.svh
// register offsets, field positions and reset values of the serial receiver
`ifndef SRX_DEFINES_SVH
`define SRX_DEFINES_SVH
`define SRX_ADDR_W 8
`define SRX_CTRL_OFS 8'h00
`define SRX_MODE_OFS 8'h04
`define SRX_PIN_OFS 8'h08
`define SRX_DIV_OFS 8'h0c
`define SRX_STAT_OFS 8'h10
`define SRX_DATA_OFS 8'h14
`define SRX_MASK_OFS 8'h18
`define SRX_CTRL_RXIRQ 6
`define SRX_CTRL_RXON 4
`define SRX_CTRL_FLTIRQ 3
`define SRX_CTRL_RSVD 2
`define SRX_CTRL_SELHI 1
`define SRX_CTRL_SELLO 0
`define SRX_MODE_SYNC 0
`define SRX_MODE_PAR 1
`define SRX_PIN_DIR 0
`define SRX_PIN_LVL 1
`define SRX_ST_READY 0
`define SRX_ST_FULL 1
`define SRX_ST_FAULT 2
`define SRX_ST_LOW 3
`define SRX_ST_OVR 4
`define SRX_NFLAGS 5
`define SRX_DIV_RST 8'h0f
`define SRX_MASK_RST 3'h7
`define SRX_OS_MID 4'h7
`define SRX_OS_END 4'hf
`endif

// File: core/srx_pkg.sv
// types shared by the serial receiver modules
package srx_pkg;
  typedef enum logic [2:0] {
    SRX_IDLE = 3'b000,
    SRX_START = 3'b001,
    SRX_DATA = 3'b010,
    SRX_PAR = 3'b011,
    SRX_STOP = 3'b100,
    SRX_WAIT_HI = 3'b101
  } srx_state_t;
  typedef logic [7:0] srx_byte_t;
endpackage

// File: core/srx_rx_if.sv
// link between the register side and the receive engine
`timescale 1ns/1ns
`default_nettype none
interface srx_rx_if;
  logic en;
  logic sync_mode;
  logic par_on;
  logic tick;
  logic rxd;
  logic done;
  srx_pkg::srx_byte_t data;
  logic frame_err;
  logic par_err;
  logic line_low;
  modport ctl(output en, sync_mode, par_on, tick, rxd,
              input done, data, frame_err, par_err, line_low);
  modport eng(input en, sync_mode, par_on, tick, rxd,
              output done, data, frame_err, par_err, line_low);
endinterface
`default_nettype wire

// File: core/srx_rx_core.sv
// receive engine: async 16x oversampling or sync bit clock
`include "srx_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module srx_rx_core (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // control and results
  srx_rx_if.eng rx
);
  import srx_pkg::*;
  srx_state_t state;
  logic [3:0] os_cnt;
  logic [2:0] bit_n;
  srx_byte_t shreg;
  logic par_acc;

  always_ff @(posedge clk_sys) begin
    rx.done <= 1'b0;
    if (!nrst || !rx.en) begin
      state <= SRX_IDLE;
      os_cnt <= 4'h0;
      bit_n <= 3'h0;
      shreg <= 8'h00;
      par_acc <= 1'b0;
      rx.data <= 8'h00;
      rx.frame_err <= 1'b0;
      rx.par_err <= 1'b0;
      rx.line_low <= 1'b0;
    end else if (rx.tick) begin
      os_cnt <= os_cnt + 4'h1;
      unique case (state)
        SRX_IDLE: begin
          os_cnt <= 4'h0;
          par_acc <= 1'b0;
          if (rx.sync_mode) begin
            shreg <= {rx.rxd, shreg[7:1]};
            bit_n <= 3'h1;
            state <= SRX_DATA;
          end else if (!rx.rxd) begin
            state <= SRX_START;
          end
        end
        SRX_START: if (os_cnt == `SRX_OS_MID) begin
          os_cnt <= 4'h0;
          bit_n <= 3'h0;
          state <= rx.rxd ? SRX_IDLE : SRX_DATA;
        end
        SRX_DATA: if (rx.sync_mode || os_cnt == `SRX_OS_END) begin
          shreg <= {rx.rxd, shreg[7:1]};
          par_acc <= par_acc ^ rx.rxd;
          bit_n <= bit_n + 3'h1;
          if (bit_n == 3'h7) begin
            if (rx.sync_mode) begin
              rx.done <= 1'b1;
              rx.data <= {rx.rxd, shreg[7:1]};
              rx.frame_err <= 1'b0;
              rx.par_err <= 1'b0;
              rx.line_low <= 1'b0;
              state <= SRX_IDLE;
            end else begin
              state <= rx.par_on ? SRX_PAR : SRX_STOP;
            end
          end
        end
        SRX_PAR: if (os_cnt == `SRX_OS_END) begin
          par_acc <= par_acc ^ rx.rxd;
          state <= SRX_STOP;
        end
        SRX_STOP: if (os_cnt == `SRX_OS_END) begin
          rx.done <= 1'b1;
          rx.data <= shreg;
          rx.frame_err <= !rx.rxd;
          rx.par_err <= rx.par_on && par_acc;
          rx.line_low <= !rx.rxd && shreg == 8'h00;
          state <= rx.rxd ? SRX_IDLE : SRX_WAIT_HI;
        end
        SRX_WAIT_HI: if (rx.rxd) begin
          state <= SRX_IDLE;
        end
        default: state <= SRX_IDLE;
      endcase
    end
  end

  a_start_detect: assert property (@(posedge clk_sys) disable iff (!nrst)
    rx.en && !rx.sync_mode && state == SRX_IDLE && rx.tick && !rx.rxd
    |=> state == SRX_START || !rx.en)
    else $error("start bit not taken");
endmodule // srx_rx_core
`default_nettype wire

// File: verification/srx_remote.sv
// remote serial party: async frames and sync clocked bytes
`timescale 1ns/1ns
`default_nettype none
module srx_remote (
  // serial lines
  output logic rxd,
  output logic sck
);
  initial begin
    rxd = 1'b1;
    sck = 1'b0;
  end
  // start bit, lsb first data, then stop level stp
  // clock of 64 ns period for 176 cycles, 16x the bit rate and as long as the frame only with 1024 ns bits
  task automatic send_async(input logic [7:0] b, input logic stp, input int bit_ns,
                            input logic ext);
    fork
      begin
        rxd = 1'b0;
        #(bit_ns);
        for (int i = 0; i < 8; i++) begin
          rxd = b[i];
          #(bit_ns);
        end
        rxd = stp;
        #(bit_ns);
        rxd = 1'b1;
        #(bit_ns);
      end
      if (ext) begin
        repeat (176) begin
          sck = 1'b1;
          #32;
          sck = 1'b0;
          #32;
        end
      end
    join
  endtask
  // data changes while the clock is low, lsb first
  task automatic send_sync(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      rxd = b[i];
      #32;
      sck = 1'b1;
      #32;
      sck = 1'b0;
    end
    rxd = 1'b1;
  endtask
endmodule // srx_remote
`default_nettype wire

// File: verification/test_srx_top.sv
// self-checking bench of the serial receiver control block
`include "srx_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module test_srx_top;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rxd_pin;
  logic sck_i;
  logic sck_o;
  logic sck_oe_n;
  logic irq;
  int n_fail = 0;
  int n_tests = 0;
  int seed = 32'h894c;
  int cnt;
  logic [64:0] expq[$];
  logic [64:0] qx;
  logic [7:0] b;
  logic prev;
  logic [3:0] pt[6] = '{4'b0000, 4'b0010, 4'b0101, 4'b1000, 4'b1010, 4'b1101};

  always #2 clk_sys = ~clk_sys;

  srx_top #(.DIV_W(8)) DUT (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd_pin(rxd_pin), .sck_i(sck_i), .sck_o(sck_o),
    .sck_oe_n(sck_oe_n), .irq(irq));
  srx_remote partner (.rxd(rxd_pin), .sck(sck_i));

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      $display("Error %s expected %h seen %h", nm, e, s);
      n_fail++;
    end
  endtask

  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask

  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    // an idle edge first, so a following call never reassigns psel at once
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      i++;
    end while (pready !== 1'b1 && i < 40);
    if (i >= 40) begin
      n_fail++;
      end_sim();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic err);
    expq.push_back({err, m, e});
    apb(1'b0, a, 32'h0);
  endtask

  task automatic settle(input int n);
    @(posedge clk_sys);
    repeat (n) @(posedge clk_sys);
  endtask

  // read results are compared against the oldest note
  always @(posedge clk_sys) begin
    if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0) begin
      qx = expq.pop_front();
      chk("prdata", qx[31:0] & qx[63:32], prdata & qx[63:32]);
      chk("pslverr", {31'h0, qx[64]}, {31'h0, pslverr});
    end
  end

  initial begin
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    chk("irq", 32'h0, {31'h0, irq});
    chk("sck_oe_n", 32'h1, {31'h0, sck_oe_n});
    rd(`SRX_CTRL_OFS, 32'h0, '1, 1'b0);
    rd(`SRX_DIV_OFS, 32'h0f, '1, 1'b0);
    rd(`SRX_MASK_OFS, 32'h7, '1, 1'b0);
    rd(`SRX_STAT_OFS, 32'h0, '1, 1'b0);
    rd(8'h1c, 32'h0, '1, 1'b1);
    apb(1'b1, `SRX_CTRL_OFS, 32'h1c);
    rd(`SRX_CTRL_OFS, 32'h18, '1, 1'b0);
    done("reset and reserved");
    // divider chosen while the receiver is off
    apb(1'b1, `SRX_CTRL_OFS, 32'h0);
    apb(1'b1, `SRX_DIV_OFS, 32'h1);
    b = 8'($random(seed));
    partner.send_async(b, 1'b1, 256, 1'b0);
    settle(20);
    rd(`SRX_STAT_OFS, 32'h0, '1, 1'b0);
    apb(1'b1, `SRX_CTRL_OFS, 32'h50);
    b = 8'($random(seed));
    partner.send_async(b, 1'b1, 256, 1'b0);
    settle(20);
    chk("irq", 32'h1, {31'h0, irq});
    rd(`SRX_STAT_OFS, 32'h3, 32'h1f, 1'b0);
    rd(`SRX_DATA_OFS, {24'h0, b}, '1, 1'b0);
    apb(1'b1, `SRX_CTRL_OFS, 32'h10);
    settle(2);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b1, `SRX_STAT_OFS, 32'h0);
    rd(`SRX_STAT_OFS, 32'h0, 32'h1f, 1'b0);
    done("async receive");
    apb(1'b1, `SRX_CTRL_OFS, 32'h18);
    partner.send_async(8'h00, 1'b0, 256, 1'b0);
    settle(20);
    chk("irq", 32'h1, {31'h0, irq});
    rd(`SRX_STAT_OFS, 32'h010c, 32'hff0c, 1'b0);
    apb(1'b1, `SRX_CTRL_OFS, 32'h10);
    settle(2);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b1, `SRX_CTRL_OFS, 32'h0);
    rd(`SRX_STAT_OFS, 32'h010c, 32'hff0c, 1'b0);
    apb(1'b1, `SRX_STAT_OFS, 32'h1f);
    rd(`SRX_STAT_OFS, 32'h010c, 32'hff0c, 1'b0);
    apb(1'b1, `SRX_STAT_OFS, 32'h0);
    rd(`SRX_STAT_OFS, 32'h0, 32'h1f, 1'b0);
    apb(1'b1, `SRX_CTRL_OFS, 32'h08);
    settle(2);
    chk("irq", 32'h0, {31'h0, irq});
    done("fault and line low");
    apb(1'b1, `SRX_PIN_OFS, 32'h3);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, `SRX_MODE_OFS, {31'h0, pt[i][3]});
      apb(1'b1, `SRX_CTRL_OFS, {30'h0, pt[i][2:1]});
      settle(3);
      chk("sck_oe_n", {31'h0, pt[i][0]}, {31'h0, sck_oe_n});
      if (i == 0) begin
        chk("sck_o", 32'h1, {31'h0, sck_o});
      end
      if (i == 1) begin
        cnt = 0;
        prev = sck_o;
        repeat (32) begin
          @(posedge clk_sys);
          cnt += (sck_o !== prev);
          prev = sck_o;
        end
        chk("sck_o toggles", 32'h1, {31'h0, cnt >= 15 && cnt <= 17});
      end
    end
    apb(1'b1, `SRX_MODE_OFS, 32'h0);
    apb(1'b1, `SRX_CTRL_OFS, 32'h0);
    apb(1'b1, `SRX_PIN_OFS, 32'h0);
    settle(3);
    chk("sck_oe_n", 32'h1, {31'h0, sck_oe_n});
    done("clock pin");
    apb(1'b1, `SRX_CTRL_OFS, 32'h12);
    b = 8'($random(seed));
    partner.send_async(b, 1'b1, 1024, 1'b1);
    settle(20);
    apb(1'b1, `SRX_STAT_OFS, 32'h0);
    rd(`SRX_STAT_OFS, 32'h3, 32'h1f, 1'b0);
    rd(`SRX_DATA_OFS, {24'h0, b}, '1, 1'b0);
    apb(1'b1, `SRX_STAT_OFS, 32'h0);
    done("external clock");
    // sync mode set before the select bits
    apb(1'b1, `SRX_CTRL_OFS, 32'h0);
    apb(1'b1, `SRX_MODE_OFS, 32'h1);
    apb(1'b1, `SRX_CTRL_OFS, 32'h12);
    b = 8'($random(seed));
    partner.send_sync(b);
    settle(20);
    rd(`SRX_DATA_OFS, {24'h0, b}, '1, 1'b0);
    rd(`SRX_STAT_OFS, 32'h3, 32'h1f, 1'b0);
    done("sync receive");
    apb(1'b1, `SRX_STAT_OFS, 32'h0);
    apb(1'b1, `SRX_CTRL_OFS, 32'h0);
    apb(1'b1, `SRX_MODE_OFS, 32'h2);
    apb(1'b1, `SRX_MASK_OFS, 32'h5);
    rd(`SRX_MASK_OFS, 32'h5, '1, 1'b0);
    apb(1'b1, `SRX_CTRL_OFS, 32'h10);
    b = 8'($random(seed));
    // with parity on, the stop-level argument goes out as the parity bit: odd for the first byte, even for the second
    partner.send_async(b, ~^b, 256, 1'b0);
    partner.send_async(~b, ^b, 256, 1'b0);
    settle(20);
    rd(`SRX_STAT_OFS, 32'h1017, 32'hff1f, 1'b0);
    rd(`SRX_DATA_OFS, {24'h0, b}, '1, 1'b0);
    done("parity and overrun");
    end_sim();
  end
endmodule // test_srx_top
`default_nettype wire
